// File: pkg/siml_pkg.sv
// Constants for the shared interrupt merge logic: register map, bit layout,
// sequencer states and instruction-cycle latencies.
// Assumes an APB master with 32-bit data and byte addresses in PADDR[7:0].
package siml_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ISTAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h10;
    // CTRL layout
    localparam int CTRL_GIE = 0;
    localparam int CTRL_CEN = 1;
    // FLAG layout: members in bits 2..0, combined flag above them
    localparam int N_MEMBER = 3;
    localparam int FLAG_TB = 0;
    localparam int FLAG_SIM = 1;
    localparam int FLAG_SPI = 2;
    localparam int FLAG_COMB = 3;
    // ISTAT / IMASK layout
    localparam int N_EVENT = 2;
    localparam int EV_CALL = 0;
    localparam int EV_WAKE = 1;
    // STAT layout
    localparam int STAT_BUSY = 0;
    localparam int STAT_FULL = 1;
    localparam int STAT_WOKEN = 2;
    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [N_MEMBER-1:0] MEMBER_RST = 3'h0;
    localparam logic [N_EVENT-1:0] IMASK_RST = 2'h0;
    // System clocks per instruction cycle, and vector latency in cycles
    localparam int CYC_DIV = 4;
    localparam logic [1:0] LAT_RUN = 2'h2;
    localparam logic [1:0] LAT_WAKE = 2'h3;
    typedef enum logic [1:0] {
        SIML_IDLE = 2'b00,
        SIML_WAIT = 2'b01
    } siml_seq_t;
endpackage

// File: pkg/siml_seq_if.sv
// Carrier between the merge logic and its vector latency sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface siml_seq_if;
    logic start;
    logic woken;
    logic abort;
    logic fire;
    logic busy;
    modport ctl (output start, output woken, output abort, input fire, input busy);
    modport seq (input start, input woken, input abort, output fire, output busy);
endinterface

// File: rtl/siml_seq.sv
// Vector latency sequencer: counts instruction cycles from an accepted
// request to the vector jump. Assumes start only while not busy.
`timescale 1ns/1ps
module siml_seq #(
    parameter int DIV = siml_pkg::CYC_DIV
) (
    input wire logic clk,
    input wire logic rstn,
    siml_seq_if.seq sq
);
    siml_pkg::siml_seq_t state;
    logic [7:0] div;
    logic [1:0] cnt;
    logic fire;
    wire tick = (div == 8'(DIV - 1));

    // Free-running divider gives the instruction-cycle enable
    always_ff @(posedge clk) begin
        if (!rstn || tick) begin
            div <= 8'h00;
        end else begin
            div <= div + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= siml_pkg::SIML_IDLE;
            cnt <= 2'h0;
            fire <= 1'b0;
        end else begin
            fire <= 1'b0;
            case (state)
                siml_pkg::SIML_IDLE: begin
                    if (sq.start) begin
                        state <= siml_pkg::SIML_WAIT;
                        cnt <= sq.woken ? siml_pkg::LAT_WAKE : siml_pkg::LAT_RUN;
                    end
                end
                siml_pkg::SIML_WAIT: begin
                    if (sq.abort) begin
                        state <= siml_pkg::SIML_IDLE;
                    end else if (tick) begin
                        if (cnt == 2'h1) begin
                            fire <= 1'b1;
                            state <= siml_pkg::SIML_IDLE;
                        end
                        cnt <= cnt - 2'h1;
                    end
                end
                default: begin
                    state <= siml_pkg::SIML_IDLE;
                end
            endcase
        end
    end

    assign sq.fire = fire;
    assign sq.busy = (state != siml_pkg::SIML_IDLE);
endmodule // siml_seq

// File: rtl/siml_top.sv
// Shared interrupt merge logic: member request flags, combined flag,
// global enable, wake-up and vector call toward the core, APB registers.
// Assumes the core pulses the exit inputs for one clock and holds
// STACK_FULL and SLEEP as levels synchronous to CLK.
// What this block does
// - Any member flag set sets combined flag
// - Pending, enabled, stack room: call combined vector
// - Service clears combined flag and global enable
// - Member flags survive service; software clears them
// - Set flags hold until serviced or cleared
// - Flag rising edge wakes from sleep
// - Flag already high gives no wake
// - Entry pushes program counter only
// - Reenabling exit restores PC, sets global enable
// - Plain exit restores PC, enable stays clear
// - No service while global enable clear
// - No acknowledge while stack full
// - Vector after 2 or 3 cycles, 3 on wake
`timescale 1ns/1ps
module siml_top (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [siml_pkg::ADDR_W-1:0] PADDR,
    input wire logic [siml_pkg::DATA_W-1:0] PWDATA,
    output logic [siml_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TIMEBASE_EVT,
    input wire logic SERIAL_MODULE_EVT,
    input wire logic SECOND_SPI_EVT,
    input wire logic SLEEP,
    input wire logic STACK_FULL,
    input wire logic EXIT_WITH_IRQ_REENABLE,
    input wire logic PLAIN_SUBROUTINE_EXIT,
    output logic CALL_VEC,
    output logic PUSH_PC,
    output logic WAKE,
    output logic IRQ
);
    localparam int NM = siml_pkg::N_MEMBER;
    localparam int NE = siml_pkg::N_EVENT;

    siml_seq_if sq ();

    logic global_irq_enable;
    logic combined_irq_enable;
    logic combined_request_flag;
    logic [NM-1:0] member;
    logic [NM-1:0] member_d;
    logic [NE-1:0] istat;
    logic [NE-1:0] imask;
    logic woken;

    // APB decode
    wire acc = PSEL && PENABLE;
    wire done = acc && PREADY;
    wire wr = done && PWRITE;
    wire sel_ctrl = (PADDR == siml_pkg::OFS_CTRL);
    wire sel_flag = (PADDR == siml_pkg::OFS_FLAG);
    wire sel_istat = (PADDR == siml_pkg::OFS_ISTAT);
    wire sel_imask = (PADDR == siml_pkg::OFS_IMASK);
    wire sel_stat = (PADDR == siml_pkg::OFS_STAT);
    wire mapped = sel_ctrl || sel_flag || sel_istat || sel_imask || sel_stat;
    wire wr_ctrl = wr && sel_ctrl;
    wire wr_flag = wr && sel_flag;
    wire wr_istat = wr && sel_istat;
    wire wr_imask = wr && sel_imask;

    wire [NM-1:0] member_evt = {SECOND_SPI_EVT, SERIAL_MODULE_EVT, TIMEBASE_EVT};
    wire [NM-1:0] member_rise = member & ~member_d;
    wire comb_set = |member_rise;

    wire pending = combined_request_flag && combined_irq_enable
        && global_irq_enable && !STACK_FULL;
    // vector taken only if still allowed
    wire took = sq.fire && pending;

    // one wake per rise: member edges, or software raising the combined flag
    wire comb_wr_rise = wr_flag && PWDATA[siml_pkg::FLAG_COMB] && !combined_request_flag;
    wire flag_rise = comb_set || comb_wr_rise;
    wire wake_evt = SLEEP && flag_rise;

    wire [NE-1:0] ev_vec = {wake_evt, took};

    wire [siml_pkg::DATA_W-1:0] ctrl_rd = {30'h0, combined_irq_enable, global_irq_enable};
    wire [siml_pkg::DATA_W-1:0] flag_rd = {28'h0, combined_request_flag, member};
    wire [siml_pkg::DATA_W-1:0] istat_rd = {30'h0, istat};
    wire [siml_pkg::DATA_W-1:0] imask_rd = {30'h0, imask};
    wire [siml_pkg::DATA_W-1:0] stat_rd = {29'h0, woken, STACK_FULL, sq.busy};
    wire [siml_pkg::DATA_W-1:0] rd_data =
        sel_ctrl ? ctrl_rd :
        sel_flag ? flag_rd :
        sel_istat ? istat_rd :
        sel_imask ? imask_rd :
        sel_stat ? stat_rd : 32'h0;

    // Sequencer hand-off; abort covers enable or stack changes mid-wait
    assign sq.start = pending && !sq.busy && !sq.fire;
    assign sq.woken = woken;
    assign sq.abort = !pending;

    siml_seq #(
        .DIV(siml_pkg::CYC_DIV)
    ) u_seq (
        .clk(CLK),
        .rstn(RSTN),
        .sq(sq)
    );

    // APB slave: one wait state, so PREADY and PRDATA come from flops
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
        end else begin
            PREADY <= acc && !PREADY;
            PSLVERR <= acc && !PREADY && !mapped;
            if (acc && !PREADY) begin
                PRDATA <= rd_data;
            end
        end
    end

    // member flags: event sets win over a software clear
    genvar i;
    generate
        for (i = 0; i < NM; i++) begin : g_member
            always_ff @(posedge CLK) begin
                if (!RSTN) begin
                    member[i] <= siml_pkg::MEMBER_RST[i];
                    member_d[i] <= 1'b0;
                end else begin
                    member[i] <= member_evt[i] || (wr_flag ? PWDATA[i] : member[i]);
                    member_d[i] <= member[i];
                end
            end
        end
    endgenerate

    // combined flag: set wins over service and write
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            combined_request_flag <= 1'b0;
        end else begin
            if (comb_set) begin
                combined_request_flag <= 1'b1;
            end else if (took) begin
                combined_request_flag <= 1'b0;
            end else if (wr_flag) begin
                combined_request_flag <= PWDATA[siml_pkg::FLAG_COMB];
            end
        end
    end

    // global enable: plain exit leaves it as it is
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            global_irq_enable <= siml_pkg::CTRL_RST[siml_pkg::CTRL_GIE];
            combined_irq_enable <= siml_pkg::CTRL_RST[siml_pkg::CTRL_CEN];
        end else begin
            if (took) begin
                global_irq_enable <= 1'b0;
            end else if (EXIT_WITH_IRQ_REENABLE) begin
                global_irq_enable <= 1'b1;
            end else if (wr_ctrl) begin
                global_irq_enable <= PWDATA[siml_pkg::CTRL_GIE];
            end
            if (wr_ctrl) begin
                combined_irq_enable <= PWDATA[siml_pkg::CTRL_CEN];
            end
        end
    end

    // remember a wake until the next accepted request
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            woken <= 1'b0;
        end else if (wake_evt) begin
            woken <= 1'b1;
        end else if (sq.start) begin
            woken <= 1'b0;
        end
    end

    // call vector, pushing the program counter and nothing else
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            CALL_VEC <= 1'b0;
            PUSH_PC <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            CALL_VEC <= took;
            PUSH_PC <= took;
            WAKE <= wake_evt;
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            istat <= '0;
            imask <= siml_pkg::IMASK_RST;
            IRQ <= 1'b0;
        end else begin
            istat <= ev_vec | (istat & ~(wr_istat ? PWDATA[NE-1:0] : 2'h0));
            if (wr_imask) begin
                imask <= PWDATA[NE-1:0];
            end
            IRQ <= |(istat & imask);
        end
    end

    sequence s_took;
        sq.fire && pending;
    endsequence

    sequence s_entry;
        CALL_VEC && PUSH_PC && !global_irq_enable;
    endsequence

    property p_comb_set;
        @(posedge CLK) disable iff (!RSTN) comb_set |=> combined_request_flag;
    endproperty
    a_comb_set: assert property (p_comb_set)
        else $error("combined flag missed member set");

    property p_call;
        @(posedge CLK) disable iff (!RSTN) s_took |=> s_entry;
    endproperty
    a_call: assert property (p_call)
        else $error("vector call missing after service");

    property p_clear;
        @(posedge CLK) disable iff (!RSTN) s_took ##0 !comb_set |=> !combined_request_flag;
    endproperty
    a_clear: assert property (p_clear)
        else $error("combined flag not cleared on service");

    property p_member_keep;
        @(posedge CLK) disable iff (!RSTN)
            (took && !wr_flag && !(|member_evt)) |=> (member == $past(member));
    endproperty
    a_member_keep: assert property (p_member_keep)
        else $error("member flag lost on service");

    property p_hold;
        @(posedge CLK) disable iff (!RSTN)
            combined_request_flag && !took && !wr_flag |=> combined_request_flag;
    endproperty
    a_hold: assert property (p_hold)
        else $error("combined flag dropped without cause");

    property p_wake;
        @(posedge CLK) disable iff (!RSTN) SLEEP && comb_set |=> WAKE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on flag rise");

    property p_reenable;
        @(posedge CLK) disable iff (!RSTN)
            EXIT_WITH_IRQ_REENABLE && !took |=> global_irq_enable;
    endproperty
    a_reenable: assert property (p_reenable)
        else $error("reenabling exit left enable low");

    property p_plain;
        @(posedge CLK) disable iff (!RSTN) PLAIN_SUBROUTINE_EXIT && !global_irq_enable
            && !wr_ctrl && !EXIT_WITH_IRQ_REENABLE |=> !global_irq_enable;
    endproperty
    a_plain: assert property (p_plain)
        else $error("plain exit changed enable");

    property p_gie_gate;
        @(posedge CLK) disable iff (!RSTN) CALL_VEC |-> $past(global_irq_enable);
    endproperty
    a_gie_gate: assert property (p_gie_gate)
        else $error("serviced with enable clear");

    property p_full_gate;
        @(posedge CLK) disable iff (!RSTN) CALL_VEC |-> !$past(STACK_FULL);
    endproperty
    a_full_gate: assert property (p_full_gate)
        else $error("serviced with stack full");

    property p_latency;
        @(posedge CLK) disable iff (!RSTN) sq.start |-> ##[6:13] (sq.fire || !sq.busy);
    endproperty
    a_latency: assert property (p_latency)
        else $error("vector latency out of range");

    property p_write;
        @(posedge CLK) disable iff (!RSTN)
            wr_flag && !comb_set && !took
            |=> combined_request_flag == $past(PWDATA[siml_pkg::FLAG_COMB]);
    endproperty
    a_write: assert property (p_write)
        else $error("flag write not taken");

    property p_no_rewake;
        @(posedge CLK) disable iff (!RSTN)
            SLEEP && combined_request_flag && !comb_set |=> !WAKE;
    endproperty
    a_no_rewake: assert property (p_no_rewake)
        else $error("wake without a flag rise");

    property p_lat_run;
        @(posedge CLK) disable iff (!RSTN)
            sq.start && !woken |-> ##[6:9] (sq.fire || !sq.busy);
    endproperty
    a_lat_run: assert property (p_lat_run)
        else $error("running vector latency out of range");

    property p_lat_wake;
        @(posedge CLK) disable iff (!RSTN)
            sq.start && woken |-> ##[10:13] (sq.fire || !sq.busy);
    endproperty
    a_lat_wake: assert property (p_lat_wake)
        else $error("wake vector latency out of range");

    property p_ev_sticky;
        @(posedge CLK) disable iff (!RSTN) took |=> istat[siml_pkg::EV_CALL];
    endproperty
    a_ev_sticky: assert property (p_ev_sticky)
        else $error("vector event not recorded");

    property p_irq_set;
        @(posedge CLK) disable iff (!RSTN) (|(istat & imask)) |=> IRQ;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("unmasked status without interrupt");

    property p_ready_wait;
        @(posedge CLK) disable iff (!RSTN) acc && !PREADY |=> PREADY;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("access not answered after one wait state");

    property p_ready_pulse;
        @(posedge CLK) disable iff (!RSTN) PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held longer than one cycle");

    property p_err_ready;
        @(posedge CLK) disable iff (!RSTN) PSLVERR |-> PREADY;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error response without ready");
endmodule // siml_top

// File: verification/siml_core_model.sv
// Behavioural core seen from the merge block: stack, vector entry, return.
// Assumes CALL_VEC and PUSH_PC are one-clock pulses on CLK.
`timescale 1ns/1ps
module siml_core_model #(
    parameter int DEPTH = 8
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CALL_VEC,
    input wire logic PUSH_PC,
    input wire logic USE_EXIT_WITH_IRQ_REENABLE,
    input wire logic SLOW,
    input wire logic HOLD_FULL,
    output logic STACK_FULL,
    output logic EXIT_WITH_IRQ_REENABLE,
    output logic PLAIN_SUBROUTINE_EXIT,
    output logic IN_ISR
);
    int sp;
    int wait_cnt;
    // One exit pulse per service, never during a new entry
    wire leave = RSTN && IN_ISR && (wait_cnt == 0) && !(CALL_VEC && PUSH_PC);
    // Bench may pin the stack full to test refusal
    assign STACK_FULL = HOLD_FULL || (sp >= DEPTH);
    always @(posedge CLK) begin
        EXIT_WITH_IRQ_REENABLE <= leave && USE_EXIT_WITH_IRQ_REENABLE;
        PLAIN_SUBROUTINE_EXIT <= leave && !USE_EXIT_WITH_IRQ_REENABLE;
        if (!RSTN) begin
            sp <= 0;
            IN_ISR <= 1'b0;
            wait_cnt <= 0;
        end else if (CALL_VEC && PUSH_PC) begin
            sp <= sp + 1;
            IN_ISR <= 1'b1;
            wait_cnt <= SLOW ? 24 : 2;
        end else if (IN_ISR) begin
            if (wait_cnt == 0) begin
                sp <= sp - 1;
                IN_ISR <= 1'b0;
            end else begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule // siml_core_model

// File: verification/tb.sv
// Self-checking bench for the shared interrupt merge block.
// Assumes one 40 MHz clock; APB reads are checked from a queue of notes.
`timescale 1ns/1ps
module tb;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [siml_pkg::ADDR_W-1:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, STACK_FULL, exr, pse, CALL_VEC, PUSH_PC, WAKE, IRQ;
    logic [2:0] evt = 3'h0;
    logic SLEEP = 1'b0;
    logic use_exit_with_irq_reenable = 1'b0;
    logic slow = 1'b0;
    logic hold_full = 1'b0;
    logic in_isr;
    logic [32:0] q[$];
    int num_errors = 0;
    int n_tests = 0;
    int ncall = 0;
    int nwake = 0;
    int seed = 32'h2069f86c;
    int n;
    int s;
    int c0;

    siml_top DUT (
        .CLK(CLK),
        .RSTN(RSTN),
        .PSEL(PSEL),
        .PENABLE(PENABLE),
        .PWRITE(PWRITE),
        .PADDR(PADDR),
        .PWDATA(PWDATA),
        .PRDATA(PRDATA),
        .PREADY(PREADY),
        .PSLVERR(PSLVERR),
        .TIMEBASE_EVT(evt[0]),
        .SERIAL_MODULE_EVT(evt[1]),
        .SECOND_SPI_EVT(evt[2]),
        .SLEEP(SLEEP),
        .STACK_FULL(STACK_FULL),
        .EXIT_WITH_IRQ_REENABLE(exr),
        .PLAIN_SUBROUTINE_EXIT(pse),
        .CALL_VEC(CALL_VEC),
        .PUSH_PC(PUSH_PC),
        .WAKE(WAKE),
        .IRQ(IRQ)
    );
    siml_core_model core (
        .CLK(CLK),
        .RSTN(RSTN),
        .CALL_VEC(CALL_VEC),
        .PUSH_PC(PUSH_PC),
        .USE_EXIT_WITH_IRQ_REENABLE(use_exit_with_irq_reenable),
        .SLOW(slow),
        .HOLD_FULL(hold_full),
        .STACK_FULL(STACK_FULL),
        .EXIT_WITH_IRQ_REENABLE(exr),
        .PLAIN_SUBROUTINE_EXIT(pse),
        .IN_ISR(in_isr)
    );

    always #12.5 CLK = ~CLK;

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Trailing idle edge keeps back-to-back calls from double-driving PSEL
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse(input int src);
        evt <= 3'h1 << src;
        @(posedge CLK);
        evt <= 3'h0;
        repeat (3) @(posedge CLK);
    endtask

    always @(posedge CLK) begin
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
            check("read data", {PSLVERR, PRDATA}, q.pop_front());
        if (CALL_VEC === 1'b1)
            ncall++;
        if (WAKE === 1'b1)
            nwake++;
    end

    initial begin
        repeat (20000) @(posedge CLK);
        num_errors++;
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
        rd(siml_pkg::OFS_CTRL, 33'h0);
        rd(siml_pkg::OFS_FLAG, 33'h0);
        rd(siml_pkg::OFS_IMASK, 33'h0);
        rd(8'h14, 33'h1_0000_0000);
        apb(1'b1, siml_pkg::OFS_FLAG, 32'h5);
        rd(siml_pkg::OFS_FLAG, 33'hD);
        apb(1'b1, siml_pkg::OFS_FLAG, 32'h0);
        $display("reset and access test done");
        apb(1'b1, siml_pkg::OFS_CTRL, 32'h2);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            rd(siml_pkg::OFS_FLAG, 33'h8 | (33'h1 << i));
            apb(1'b1, siml_pkg::OFS_FLAG, 32'h0);
        end
        check("no call while disabled", ncall, 0);
        $display("merge test done");
        apb(1'b1, siml_pkg::OFS_IMASK, 32'h1);
        for (int k = 0; k < 4; k++) begin
            s = {$random(seed)} % 3;
            use_exit_with_irq_reenable <= k[0];
            slow <= k[1];
            apb(1'b1, siml_pkg::OFS_CTRL, 32'h3);
            evt <= 3'h1 << s;
            n = 0;
            do begin
                @(posedge CLK);
                evt <= 3'h0;
                n++;
            end while (CALL_VEC !== 1'b1 && n < 40);
            check("vector delay", n >= 9 && n <= 13, 1);
            check("push with call", PUSH_PC, 1);
            if (k[1])
                rd(siml_pkg::OFS_CTRL, 33'h2);
            rd(siml_pkg::OFS_FLAG, 33'h1 << s);
            rd(siml_pkg::OFS_ISTAT, 33'h1);
            check("irq", IRQ, 1);
            n = 0;
            while (in_isr !== 1'b0 && n < 60) begin
                @(posedge CLK);
                n++;
            end
            rd(siml_pkg::OFS_CTRL, k[0] ? 33'h3 : 33'h2);
            apb(1'b1, siml_pkg::OFS_FLAG, 32'h0);
            apb(1'b1, siml_pkg::OFS_ISTAT, 32'h3);
            rd(siml_pkg::OFS_ISTAT, 33'h0);
            check("irq cleared", IRQ, 0);
        end
        $display("service test done");
        hold_full <= 1'b1;
        use_exit_with_irq_reenable <= 1'b1;
        slow <= 1'b0;
        apb(1'b1, siml_pkg::OFS_CTRL, 32'h3);
        c0 = ncall;
        pulse(1);
        repeat (30) @(posedge CLK);
        check("no call on full stack", ncall, c0);
        rd(siml_pkg::OFS_STAT, 33'h2);
        hold_full <= 1'b0;
        n = 0;
        while (ncall == c0 && n < 40) begin
            @(posedge CLK);
            n++;
        end
        check("call after room", ncall, c0 + 1);
        repeat (10) @(posedge CLK);
        apb(1'b1, siml_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, siml_pkg::OFS_FLAG, 32'h0);
        apb(1'b1, siml_pkg::OFS_ISTAT, 32'h3);
        $display("stack test done");
        SLEEP <= 1'b1;
        c0 = nwake;
        pulse(2);
        check("wake on rise", nwake, c0 + 1);
        pulse(2);
        check("no wake when high", nwake, c0 + 1);
        rd(siml_pkg::OFS_ISTAT, 33'h2);
        SLEEP <= 1'b0;
        apb(1'b1, siml_pkg::OFS_CTRL, 32'h3);
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (CALL_VEC !== 1'b1 && n < 40);
        check("wake vector delay", n >= 11 && n <= 14, 1);
        rd(siml_pkg::OFS_FLAG, 33'h4);
        $display("wake test done");
        end_of_test();
    end
endmodule // tb
